// File: crtv_line_source.sv
`timescale 1ns/10ps
`default_nettype none
// horizontal side: one retrace pulse per LINE_LEN cycles
module crtv_line_source #(
    parameter int LINE_LEN = 16
) (
    input wire logic ref_clk,
    input wire logic run,
    output logic line_pulse,
    output logic h_display,
    output logic char_clk_en
);
    // outputs settle at the first falling edge, well inside reset
    int pos = 0;
    always @(negedge ref_clk) begin
        pos = (run && pos < LINE_LEN - 1) ? pos + 1 : 0;
        line_pulse <= run && pos == 0;
        h_display <= run && pos >= 4 && pos < 12;
        // char clock stands still while run is low
        char_clk_en <= run;
    end
endmodule : crtv_line_source
`default_nettype wire

// File: crtv_pkg.sv
package crtv_pkg;
    // host port selects
    localparam logic [1:0] SEL_INDEX = 2'h0;
    localparam logic [1:0] SEL_DATA = 2'h1;
    localparam logic [1:0] SEL_STATUS = 2'h2;

    // register indices held by this block
    localparam logic [4:0] IDX_VTOTAL = 5'h06;
    localparam logic [4:0] IDX_VERT_HIGH = 5'h07;
    localparam logic [4:0] IDX_ROW_PRESET = 5'h08;
    localparam logic [4:0] IDX_ROW_HEIGHT = 5'h09;
    localparam logic [4:0] IDX_CURSOR_TOP = 5'h0a;
    localparam logic [4:0] IDX_CURSOR_BOTTOM = 5'h0b;
    localparam logic [4:0] IDX_ORIGIN_HIGH = 5'h0c;
    localparam logic [4:0] IDX_ORIGIN_LOW = 5'h0d;
    localparam logic [4:0] IDX_CURSOR_POS_HIGH = 5'h0e;
    localparam logic [4:0] IDX_CURSOR_POS_LOW = 5'h0f;
    localparam logic [4:0] IDX_VSYNC_BEGIN = 5'h10;
    localparam logic [4:0] IDX_VSYNC_END_IRQ = 5'h11;
    localparam logic [4:0] IDX_VISIBLE_END = 5'h12;
    localparam logic [4:0] IDX_ROW_PITCH = 5'h13;
    localparam logic [4:0] IDX_PROTECT_LAST = 5'h07;
    localparam int NUM_REGS = 14;

    // vertical_high_bits field positions
    localparam int VH_VTOTAL8 = 0;
    localparam int VH_VDE8 = 1;
    localparam int VH_VRS8 = 2;
    localparam int VH_VBS8 = 3;
    localparam int VH_LC8 = 4;
    localparam int VH_VTOTAL9 = 5;
    localparam int VH_VDE9 = 6;
    localparam int VH_VRS9 = 7;
    // row_scan_preset / row_height_control
    localparam int RP_PAN_LSB = 5;
    localparam int RH_DOUBLE = 7;
    localparam int RH_LC9 = 6;
    localparam int RH_VBS9 = 5;
    // cursor_top / cursor_bottom
    localparam int CT_OFF = 5;
    localparam int CB_SKEW_LSB = 5;
    // vsync_end_and_irq
    localparam int VE_PROTECT = 7;
    localparam int VE_REFRESH5 = 6;
    localparam int VE_IRQ_EN_N = 5;
    localparam int VE_CLEAR_N = 4;
    // status register
    localparam int ST_IRQ = 7;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] REFRESH_FIVE = 3'h5;
    localparam logic [2:0] REFRESH_THREE = 3'h3;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic [4:0] index;
        logic [7:0] rdata;
        logic [9:0] vcount;
        logic [4:0] row_scan;
        logic dbl_phase;
        logic [15:0] row_addr;
        logic [15:0] ma;
        logic [15:0] origin_latch;
        logic vretrace;
        logic vde;
        logic irq_pend;
        logic irq_line;
        logic [2:0] cursor_pipe;
        logic cursor;
    } crtv_state_t;
endpackage : crtv_pkg

// File: crtv_timing.sv
// Functional notes
// - vertical_high_bits supply high timing bits
// - preset row scan starts first row
// - row scan wraps to zero, not preset
// - byte panning bits extend pel panning
// - origin latched at vertical retrace start
// - double scan halves row scan clock
// - maximum scan line sets row wrap
// - row height holds compare/blank bit 9
// - cursor-off bit suppresses cursor
// - start above end shows no cursor
// - cursor skew delays 0 to 3 chars
// - 16-bit origin from two bytes
// - 16-bit cursor position from two bytes
// - retrace start in lines, high bits overflow
// - protect blocks writes 00-07 except LC8
// - refresh select five or three, reset clear
// - active-low irq enable, shared line, status
// - flip-flop set at display end, held clear
// - retrace ends on low four bits match
// - 10-bit display end line value
// - next row adds pitch times 2 or 4
// - vertical total is lines minus two
`timescale 1ns/10ps
`default_nettype none
module crtv_timing (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [1:0] host_sel,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic char_clk_en,
    input wire logic line_pulse,
    input wire logic h_display,
    input wire logic dword_mode,
    output logic [15:0] mem_addr,
    output logic [4:0] row_scan,
    output logic [1:0] byte_pan,
    output logic cursor_out,
    output logic vretrace_out,
    output logic vdisplay_out,
    output logic shared_host_irq_line,
    output logic [2:0] refresh_cycles,
    output logic [9:0] vtotal_value,
    output logic [9:0] vdisplay_end_value,
    output logic [9:0] vsync_start_value,
    output logic [1:0] vblank_start_high,
    output logic [1:0] line_compare_high
);
    crtv_pkg::crtv_state_t s_ff;
    crtv_pkg::crtv_state_t nxt_s;

    logic [7:0] r_vt;
    logic [7:0] r_vh;
    logic [7:0] r_rp;
    logic [7:0] r_rh;
    logic [7:0] r_ct;
    logic [7:0] r_cb;
    logic [7:0] r_ve;
    logic [15:0] origin;
    logic [15:0] cursor_pos;
    logic [15:0] pitch_step;
    logic [9:0] vtotal;
    logic [9:0] vde_end;
    logic [9:0] vrs;
    logic [4:0] max_scan;
    logic [4:0] wr_slot;
    logic in_range;
    logic frame_wrap;
    logic row_tick;
    logic cursor_hit;
    logic [3:0] cursor_taps;

    assign r_vt = s_ff.regs[crtv_pkg::IDX_VTOTAL - crtv_pkg::IDX_VTOTAL];
    assign r_vh = s_ff.regs[crtv_pkg::IDX_VERT_HIGH - crtv_pkg::IDX_VTOTAL];
    assign r_rp = s_ff.regs[crtv_pkg::IDX_ROW_PRESET - crtv_pkg::IDX_VTOTAL];
    assign r_rh = s_ff.regs[crtv_pkg::IDX_ROW_HEIGHT - crtv_pkg::IDX_VTOTAL];
    assign r_ct = s_ff.regs[crtv_pkg::IDX_CURSOR_TOP - crtv_pkg::IDX_VTOTAL];
    assign r_cb = s_ff.regs[crtv_pkg::IDX_CURSOR_BOTTOM - crtv_pkg::IDX_VTOTAL];
    assign r_ve = s_ff.regs[crtv_pkg::IDX_VSYNC_END_IRQ - crtv_pkg::IDX_VTOTAL];
    assign origin = {s_ff.regs[crtv_pkg::IDX_ORIGIN_HIGH - crtv_pkg::IDX_VTOTAL],
        s_ff.regs[crtv_pkg::IDX_ORIGIN_LOW - crtv_pkg::IDX_VTOTAL]};
    assign cursor_pos = {
        s_ff.regs[crtv_pkg::IDX_CURSOR_POS_HIGH - crtv_pkg::IDX_VTOTAL],
        s_ff.regs[crtv_pkg::IDX_CURSOR_POS_LOW - crtv_pkg::IDX_VTOTAL]};
    assign vtotal = {r_vh[crtv_pkg::VH_VTOTAL9], r_vh[crtv_pkg::VH_VTOTAL8], r_vt};
    assign vde_end = {r_vh[crtv_pkg::VH_VDE9], r_vh[crtv_pkg::VH_VDE8],
        s_ff.regs[crtv_pkg::IDX_VISIBLE_END - crtv_pkg::IDX_VTOTAL]};
    assign vrs = {r_vh[crtv_pkg::VH_VRS9], r_vh[crtv_pkg::VH_VRS8],
        s_ff.regs[crtv_pkg::IDX_VSYNC_BEGIN - crtv_pkg::IDX_VTOTAL]};
    assign max_scan = r_rh[4:0];
    assign pitch_step = dword_mode ?
        {6'h00, s_ff.regs[crtv_pkg::IDX_ROW_PITCH - crtv_pkg::IDX_VTOTAL], 2'h0} :
        {7'h00, s_ff.regs[crtv_pkg::IDX_ROW_PITCH - crtv_pkg::IDX_VTOTAL], 1'h0};

    assign wr_slot = s_ff.index - crtv_pkg::IDX_VTOTAL;
    assign in_range = (s_ff.index >= crtv_pkg::IDX_VTOTAL) &&
        (s_ff.index <= crtv_pkg::IDX_ROW_PITCH);
    // lines per frame is total plus two
    assign frame_wrap = line_pulse && (s_ff.vcount == vtotal + 10'h001);
    assign row_tick = line_pulse &&
        (!r_rh[crtv_pkg::RH_DOUBLE] || s_ff.dbl_phase);

    assign cursor_hit = !r_ct[crtv_pkg::CT_OFF] &&
        (r_ct[4:0] <= r_cb[4:0]) &&
        (s_ff.row_scan >= r_ct[4:0]) && (s_ff.row_scan <= r_cb[4:0]) &&
        (s_ff.ma == cursor_pos) && s_ff.vde && h_display;
    assign cursor_taps = {s_ff.cursor_pipe, cursor_hit};

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rdata = s_ff.rdata;
        // host port: index, data and status selects
        if (host_wr && host_sel == crtv_pkg::SEL_INDEX) begin
            nxt_s.index = host_wdata[4:0];
        end
        if (host_wr && host_sel == crtv_pkg::SEL_DATA && in_range) begin
            if (r_ve[crtv_pkg::VE_PROTECT] &&
                s_ff.index <= crtv_pkg::IDX_PROTECT_LAST) begin
                if (s_ff.index == crtv_pkg::IDX_VERT_HIGH) begin
                    nxt_s.regs[wr_slot[3:0]][crtv_pkg::VH_LC8] =
                        host_wdata[crtv_pkg::VH_LC8];
                end
            end else begin
                nxt_s.regs[wr_slot[3:0]] = host_wdata;
            end
        end
        if (host_rd) begin
            case (host_sel)
                crtv_pkg::SEL_INDEX: nxt_s.rdata = {3'h0, s_ff.index};
                crtv_pkg::SEL_DATA: begin
                    nxt_s.rdata = in_range ? s_ff.regs[wr_slot[3:0]] : 8'h00;
                end
                crtv_pkg::SEL_STATUS: begin
                    nxt_s.rdata = 8'h00;
                    nxt_s.rdata[crtv_pkg::ST_IRQ] = s_ff.irq_pend;
                end
                default: nxt_s.rdata = 8'h00;
            endcase
        end

        // refresh address counter runs along the line
        if (char_clk_en && h_display) begin
            nxt_s.ma = s_ff.ma + 16'h0001;
        end

        if (line_pulse) begin
            nxt_s.vcount = s_ff.vcount + 10'h001;
            nxt_s.dbl_phase = !s_ff.dbl_phase;
            nxt_s.ma = s_ff.row_addr;
            if (row_tick) begin
                if (s_ff.row_scan == max_scan) begin
                    nxt_s.row_scan = 5'h00;
                    nxt_s.row_addr = s_ff.row_addr + pitch_step;
                    nxt_s.ma = s_ff.row_addr + pitch_step;
                end else begin
                    nxt_s.row_scan = s_ff.row_scan + 5'h01;
                end
            end
            if (s_ff.vcount == vrs) begin
                nxt_s.vretrace = 1'b1;
                nxt_s.origin_latch = origin;
            end
            // retrace end on low four bits
            if (s_ff.vretrace && s_ff.vcount[3:0] == r_ve[3:0]) begin
                nxt_s.vretrace = 1'b0;
            end
            if (s_ff.vcount == vde_end) begin
                nxt_s.vde = 1'b0;
                // set at end of active display
                nxt_s.irq_pend = 1'b1;
            end
            if (frame_wrap) begin
                nxt_s.vcount = 10'h000;
                nxt_s.vde = 1'b1;
                nxt_s.dbl_phase = 1'b0;
                // preset row scan for first row
                nxt_s.row_scan = r_rp[4:0];
                nxt_s.row_addr = s_ff.origin_latch;
                nxt_s.ma = s_ff.origin_latch;
            end
        end

        // clear bit low holds flip-flop cleared
        if (!r_ve[crtv_pkg::VE_CLEAR_N]) begin
            nxt_s.irq_pend = 1'b0;
        end
        nxt_s.irq_line = nxt_s.irq_pend && !r_ve[crtv_pkg::VE_IRQ_EN_N];

        if (char_clk_en) begin
            nxt_s.cursor_pipe = cursor_taps[2:0];
            nxt_s.cursor = cursor_taps[r_cb[6:5]];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign host_rdata = s_ff.rdata;
    assign mem_addr = s_ff.ma;
    assign row_scan = s_ff.row_scan;
    // byte panning extension out to shifter
    assign byte_pan = r_rp[6:5];
    assign cursor_out = s_ff.cursor;
    assign vretrace_out = s_ff.vretrace;
    assign vdisplay_out = s_ff.vde;
    assign shared_host_irq_line = s_ff.irq_line;
    assign refresh_cycles = r_ve[crtv_pkg::VE_REFRESH5] ?
        crtv_pkg::REFRESH_FIVE : crtv_pkg::REFRESH_THREE;
    assign vtotal_value = vtotal;
    assign vdisplay_end_value = vde_end;
    assign vsync_start_value = vrs;
    // bits 9 and 8 of blank start and compare
    assign vblank_start_high = {r_rh[crtv_pkg::RH_VBS9],
        r_vh[crtv_pkg::VH_VBS8]};
    assign line_compare_high = {r_rh[crtv_pkg::RH_LC9],
        r_vh[crtv_pkg::VH_LC8]};

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_protect_low_idx: assert property (
        (host_wr && host_sel == crtv_pkg::SEL_DATA && r_ve[7] &&
         s_ff.index == crtv_pkg::IDX_VTOTAL) |=> $stable(r_vt))
        else $error("protected vertical total was written");

    a_protect_lc8: assert property (
        (host_wr && host_sel == crtv_pkg::SEL_DATA && r_ve[7] &&
         s_ff.index == crtv_pkg::IDX_VERT_HIGH)
        |=> (r_vh[4] == $past(host_wdata[4])) &&
            (r_vh[3:0] == $past(r_vh[3:0])) &&
            (r_vh[7:5] == $past(r_vh[7:5])))
        else $error("line compare bit not the only writable bit");

    a_row_wraps_zero: assert property (
        (row_tick && !frame_wrap && s_ff.row_scan == max_scan)
        |=> (s_ff.row_scan == 5'h00))
        else $error("row scan did not clear at maximum");

    a_frame_preset: assert property (
        frame_wrap |=> (s_ff.row_scan == $past(r_rp[4:0])) &&
            (s_ff.vcount == 10'h000) &&
            (s_ff.ma == $past(s_ff.origin_latch)))
        else $error("frame start missed preset or origin");

    a_double_hold: assert property (
        (line_pulse && r_rh[7] && !s_ff.dbl_phase && !frame_wrap)
        |=> $stable(s_ff.row_scan))
        else $error("row scan advanced on skipped line");

    a_origin_latch: assert property (
        (line_pulse && s_ff.vcount == vrs)
        |=> s_ff.vretrace && (s_ff.origin_latch == $past(origin)))
        else $error("origin not latched at retrace start");

    a_retrace_end: assert property (
        (line_pulse && s_ff.vretrace && s_ff.vcount != vrs &&
         s_ff.vcount[3:0] == r_ve[3:0]) |=> !s_ff.vretrace)
        else $error("vertical retrace did not end");

    a_irq_held_clear: assert property (
        (!r_ve[4]) [*2] |-> !s_ff.irq_pend && !shared_host_irq_line)
        else $error("interrupt not held cleared");

    a_irq_set_end: assert property (
        (line_pulse && s_ff.vcount == vde_end && r_ve[4] &&
         !(host_wr && host_sel == crtv_pkg::SEL_DATA))
        |=> s_ff.irq_pend ##0 !s_ff.vde)
        else $error("interrupt not set at display end");

    a_irq_gate: assert property (
        shared_host_irq_line |-> $past(r_ve[5]) == 1'b0)
        else $error("interrupt driven while disabled");

    a_cursor_off: assert property (
        (r_ct[5] && $past(r_ct[5]) && $past(r_ct[5], 4) && $past(r_ct[5], 2)
         && $past(r_ct[5], 3)) |-> !cursor_out)
        else $error("cursor shown while switched off");

    a_refresh_sel: assert property (
        $rose(r_ve[6]) |-> refresh_cycles == 3'h5)
        else $error("refresh count not five");
endmodule : crtv_timing
`default_nettype wire

// File: test_crtv_timing.sv
`timescale 1ns/10ps
`default_nettype none
module test_crtv_timing;
    localparam int LINE = 8'h10;
    localparam logic [4:0] CI [0:13] = '{5'h11, 5'h06, 5'h07, 5'h08,
        5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h12, 5'h13};
    localparam logic [7:0] CV [0:13] = '{8'h1f, 8'h14, 8'h00, 8'h01,
        8'h01, 8'h00, 8'h1f, 8'h12, 8'h34, 8'h12, 8'h36, 8'h0c, 8'h09, 8'h03};
    logic ref_clk, resetn, host_wr, host_rd, dword_mode, run;
    logic char_clk_en, line_pulse, h_display, cursor_out, vretrace_out;
    logic vdisplay_out, shared_host_irq_line;
    logic [1:0] host_sel, byte_pan, vblank_start_high, line_compare_high;
    logic [7:0] host_wdata, host_rdata, rv;
    logic [15:0] mem_addr;
    logic [4:0] row_scan;
    logic [2:0] refresh_cycles;
    logic [9:0] vtotal_value, vdisplay_end_value, vsync_start_value;
    logic [15:0] f_addr [0:4];
    logic [4:0] f_row [0:4];
    int n_errors, n_checks, f_len, f_vde, f_vrt, f_cf, f_cn, cf0;

    crtv_line_source #(.LINE_LEN(LINE)) src (.ref_clk, .run, .line_pulse,
        .h_display, .char_clk_en);
    crtv_timing dut (.ref_clk, .resetn, .host_sel, .host_wr, .host_rd,
        .host_wdata, .host_rdata, .char_clk_en, .line_pulse, .h_display,
        .dword_mode, .mem_addr, .row_scan, .byte_pan, .cursor_out,
        .vretrace_out, .vdisplay_out, .shared_host_irq_line, .refresh_cycles,
        .vtotal_value, .vdisplay_end_value, .vsync_start_value,
        .vblank_start_high, .line_compare_high);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge ref_clk);
        host_sel = s;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge ref_clk);
        host_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] s);
        @(negedge ref_clk);
        host_sel = s;
        host_rd = 1'b1;
        @(negedge ref_clk);
        host_rd = 1'b0;
        @(negedge ref_clk);
        rv = host_rdata;
    endtask : rd

    task automatic rw(input logic [4:0] i, input logic [7:0] d);
        wr(crtv_pkg::SEL_INDEX, {3'h0, i});
        wr(crtv_pkg::SEL_DATA, d);
    endtask : rw

    task automatic rr(input logic [4:0] i);
        wr(crtv_pkg::SEL_INDEX, {3'h0, i});
        rd(crtv_pkg::SEL_DATA);
    endtask : rr

    task automatic wait_rise();
        logic p;
        p = vdisplay_out;
        for (int k = 0; k < 3000; k++) begin
            @(negedge ref_clk);
            if (vdisplay_out === 1'b1 && p === 1'b0) return;
            p = vdisplay_out;
        end
        chk(16'h0000, 16'h0001);
        finish_test();
    endtask : wait_rise

    // skip one frame so that fresh settings are latched
    task automatic frame();
        logic p;
        wait_rise();
        wait_rise();
        f_len = 0;
        f_vde = 0;
        f_vrt = 0;
        f_cf = -1;
        f_cn = 0;
        p = 1'b1;
        while (f_len < 3000) begin
            if (f_len % LINE == 0 && f_len / LINE < 5) begin
                f_row[f_len / LINE] = row_scan;
                f_addr[f_len / LINE] = mem_addr;
            end
            f_vde += int'(vdisplay_out === 1'b1);
            f_vrt += int'(vretrace_out === 1'b1);
            if (cursor_out === 1'b1) begin
                if (f_cf < 0) f_cf = f_len;
                f_cn++;
            end
            f_len++;
            @(negedge ref_clk);
            if (vdisplay_out === 1'b1 && p === 1'b0) break;
            p = vdisplay_out;
        end
        // a frame that never closes is a hang, not a result
        if (f_len >= 3000) begin
            chk(16'(f_len), 16'h0000);
            finish_test();
        end
    endtask : frame

    task automatic t_regs();
        chk(16'(refresh_cycles), 16'h0003);
        rr(5'h11);
        chk(16'(rv), 16'h0000);
        rw(5'h07, 8'ha5);
        rw(5'h06, 8'h12);
        rw(5'h12, 8'h34);
        rw(5'h10, 8'h56);
        rw(5'h09, 8'h60);
        rw(5'h08, 8'h60);
        rw(5'h11, 8'h40);
        chk(16'(vtotal_value), 16'h0312);
        chk(16'(vdisplay_end_value), 16'h0034);
        chk(16'(vsync_start_value), 16'h0356);
        chk(16'(vblank_start_high), 16'h0002);
        chk(16'(line_compare_high), 16'h0002);
        chk(16'(byte_pan), 16'h0003);
        chk(16'(refresh_cycles), 16'h0005);
        rw(5'h14, 8'h77);
        rr(5'h14);
        chk(16'(rv), 16'h0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_protect();
        rw(5'h11, 8'h80);
        rw(5'h07, 8'h10);
        rw(5'h06, 8'h00);
        rr(5'h07);
        chk(16'(rv), 16'h00b5);
        rr(5'h06);
        chk(16'(rv), 16'h0012);
        rw(5'h11, 8'h00);
        rw(5'h06, 8'h00);
        rr(5'h06);
        chk(16'(rv), 16'h0000);
        rd(crtv_pkg::SEL_STATUS);
        chk(16'(rv[crtv_pkg::ST_IRQ]), 16'h0000);
        $display("test protect done");
    endtask : t_protect

    task automatic t_frame();
        frame();
        chk(16'(f_len), 16'((8'h14 + 2) * LINE));
        chk(16'(f_vde), 16'((8'h09 + 1) * LINE));
        chk(16'(f_vrt), 16'((8'h0f - 8'h0c) * LINE));
        chk(f_addr[0], 16'h1234);
        chk(16'(f_row[0]), 16'h0001);
        chk(16'(f_row[1]), 16'h0000);
        chk(f_addr[1], 16'h1234 + 16'h0006);
        dword_mode = 1'b1;
        frame();
        chk(f_addr[1], 16'h1234 + 16'h000c);
        dword_mode = 1'b0;
        rw(5'h08, 8'h00);
        rw(5'h09, 8'h03);
        frame();
        chk(16'(f_row[2]), 16'h0002);
        chk(16'(f_row[4]), 16'h0000);
        rw(5'h09, 8'h83);
        frame();
        chk(16'(f_row[2]), 16'h0001);
        chk(16'(f_row[4]), 16'h0002);
        rw(5'h08, 8'h01);
        rw(5'h09, 8'h01);
        $display("test frame done");
    endtask : t_frame

    task automatic t_cursor();
        frame();
        cf0 = f_cf;
        chk(16'(f_cn != 0), 16'h0001);
        rw(5'h0b, 8'h7f);
        frame();
        chk(16'(f_cf), 16'(cf0 + 3));
        rw(5'h0e, 8'h00);
        frame();
        chk(16'(f_cn), 16'h0000);
        rw(5'h0e, 8'h12);
        rw(5'h0a, 8'h20);
        frame();
        chk(16'(f_cn), 16'h0000);
        rw(5'h0a, 8'h05);
        rw(5'h0b, 8'h02);
        frame();
        chk(16'(f_cn), 16'h0000);
        $display("test cursor done");
    endtask : t_cursor

    task automatic t_irq();
        rd(crtv_pkg::SEL_STATUS);
        chk(16'(rv[crtv_pkg::ST_IRQ]), 16'h0001);
        chk(16'(shared_host_irq_line), 16'h0001);
        // acknowledge: clear bit low, then high again
        rw(5'h11, 8'h0f);
        rd(crtv_pkg::SEL_STATUS);
        chk(16'(rv[crtv_pkg::ST_IRQ]), 16'h0000);
        chk(16'(shared_host_irq_line), 16'h0000);
        rw(5'h11, 8'h3f);
        frame();
        rd(crtv_pkg::SEL_STATUS);
        chk(16'(rv[crtv_pkg::ST_IRQ]), 16'h0001);
        chk(16'(shared_host_irq_line), 16'h0000);
        $display("test irq done");
    endtask : t_irq

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    initial begin
        resetn = 1'b0;
        host_sel = 2'h0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
        dword_mode = 1'b0;
        run = 1'b0;
        n_errors = 0;
        n_checks = 0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        t_regs();
        t_protect();
        // settings written before the frames start
        for (int i = 0; i < 14; i++) rw(CI[i], CV[i]);
        run = 1'b1;
        t_frame();
        t_cursor();
        t_irq();
        finish_test();
    end
endmodule : test_crtv_timing
`default_nettype wire
